// ### rtl/rtcrc_defs.svh
// Constants for the contactless timer clock and reload control block.
// Assumes a 40 MHz system clock; included by bare name.
`ifndef RTCRC_DEFS_SVH
`define RTCRC_DEFS_SVH

// Clock rates in kHz
`define RTCRC_SYS_CLK_KHZ 40000
`define RTCRC_CONTACTLESS_INTERFACE_CLK_KHZ 13560
// Phase accumulator width, holds the sum before the wrap
`define RTCRC_ACC_W 17
// Timer count width
`define RTCRC_CNT_W 20
// Prescaler counter width, enough for the divide by 256
`define RTCRC_DIV_W 8
// Reset values of the configuration fields
`define RTCRC_SRC_RST 1'h0
`define RTCRC_DIV_RST 3'h0
`define RTCRC_RELOAD_RST 1'h0

`endif

// ### rtl/rtcrc_pkg.sv
// Types shared by the contactless timer clock and reload control block.
// Assumes the constants header is available on the include path.
package rtcrc_pkg;
   `include "rtcrc_defs.svh"

   typedef logic [`RTCRC_CNT_W-1:0] rtcrc_count_t;
   typedef logic [2:0] rtcrc_div_sel_t;

   typedef enum logic [1:0] {
      RTCRC_IDLE = 2'b01,
      RTCRC_RUN = 2'b10
   } rtcrc_state_t;
endpackage

// ### rtl/rtcrc_timer.sv
// Down-counting timer with tick source selection, prescaler and reload control.
// Assumes all inputs are synchronous to CLK; configuration arrives as plain pins.
`timescale 1ns/10ps

// Rates, widths and reset values of the configuration fields
`include "rtcrc_defs.svh"

// Behaviour
// - Source bit 0: tick at 13.56 MHz
// - Source bit 1: tick from prescaler selection
// - Reload 0: stop at zero on expiry
// - Reload 1: reload preset, keep counting down
// - Divider 010..111 give 1.70 MHz to 53 kHz
// - Divider 000 6.78 MHz, 001 3.39 MHz
module rtcrc_timer (
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic TIMER1_CLOCK_SOURCE_SELECT,
   input wire rtcrc_pkg::rtcrc_div_sel_t TIMER1_DIVIDER_SELECT,
   input wire logic TIMER1_AUTO_RELOAD,
   input wire rtcrc_pkg::rtcrc_count_t PRESET,
   input wire logic START,
   input wire logic STOP,
   output logic TIMER_TICK,
   output rtcrc_pkg::rtcrc_count_t COUNT,
   output logic RUNNING,
   output logic EXPIRED
);
   import rtcrc_pkg::*;

   localparam logic [`RTCRC_ACC_W-1:0] ACC_STEP = `RTCRC_ACC_W'(`RTCRC_CONTACTLESS_INTERFACE_CLK_KHZ);
   localparam logic [`RTCRC_ACC_W-1:0] ACC_MOD = `RTCRC_ACC_W'(`RTCRC_SYS_CLK_KHZ);

   logic [`RTCRC_ACC_W-1:0] acc;
   logic [`RTCRC_ACC_W-1:0] next_acc;
   logic contactless_interface_tick;
   logic [`RTCRC_DIV_W-1:0] div_cnt;
   logic [`RTCRC_DIV_W-1:0] div_mask;
   logic pre_tick;
   logic tick;
   rtcrc_state_t state;
   rtcrc_count_t count;
   rtcrc_state_t next_state;
   rtcrc_count_t next_count;
   logic next_expired;
   logic start_req;
   logic stop_req;
   logic tick_req;
   logic at_end;

   // Fractional accumulator: an average 13.56 MHz enable out of 40 MHz.
   // Each clock adds the interface rate; a wrap past the system rate is one tick,
   // so ticks fall two or three clocks apart and never on adjacent clocks.
   always_comb begin
      next_acc = acc + ACC_STEP;
      contactless_interface_tick = 1'b0;
      if (next_acc >= ACC_MOD) begin
         contactless_interface_tick = 1'b1;
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         acc <= '0;
      end else if (contactless_interface_tick) begin
         acc <= next_acc - ACC_MOD;
      end else begin
         acc <= next_acc;
      end
   end

   // Prescaler counts interface ticks; it free-runs so the tick phase is steady
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         div_cnt <= '0;
      end else if (contactless_interface_tick) begin
         div_cnt <= div_cnt + `RTCRC_DIV_W'(1);
      end
   end

   // Divide by 2^(sel+1): 000 is 6.78 MHz, 111 is 53 kHz
   always_comb begin
      case (TIMER1_DIVIDER_SELECT)
         3'h0: div_mask = 8'h01;
         3'h1: div_mask = 8'h03;
         3'h2: div_mask = 8'h07;
         3'h3: div_mask = 8'h0F;
         3'h4: div_mask = 8'h1F;
         3'h5: div_mask = 8'h3F;
         3'h6: div_mask = 8'h7F;
         3'h7: div_mask = 8'hFF;
         default: div_mask = 8'h01;
      endcase
   end

   assign pre_tick = contactless_interface_tick && ((div_cnt & div_mask) == div_mask);

   // Tick source: direct interface clock or prescaled tick
   assign tick = TIMER1_CLOCK_SOURCE_SELECT ? pre_tick : contactless_interface_tick;

   // Request decode: stop beats start, and start beats a tick in the same cycle.
   // A start with stop present is refused in every state, so a stray start
   // cannot slip past a stop that software meant to win.
   assign stop_req = STOP;
   assign start_req = START && !STOP;
   assign tick_req = tick && !START && !STOP;

   // Expiry point: a tick that finds the count at one or zero takes it to zero, or to PRESET with reload
   assign at_end = (count <= rtcrc_count_t'(1));

   // Next run state: idle until started, back to idle on stop or final expiry
   always_comb begin
      next_state = state;
      case (state)
         RTCRC_IDLE: begin
            if (start_req) begin
               next_state = RTCRC_RUN;
            end
         end
         RTCRC_RUN: begin
            if (stop_req) begin
               next_state = RTCRC_IDLE;
            end else if (tick_req && at_end && !TIMER1_AUTO_RELOAD) begin
               next_state = RTCRC_IDLE;
            end
         end
         default: begin
            next_state = RTCRC_IDLE;
         end
      endcase
   end

   // Next count: load on start, step down per tick, reload or clear on expiry.
   // Stop leaves the count where it is so software can read how far it got.
   always_comb begin
      next_count = count;
      case (state)
         RTCRC_IDLE: begin
            if (start_req) begin
               next_count = PRESET;
            end
         end
         RTCRC_RUN: begin
            if (stop_req) begin
               next_count = count;
            end else if (start_req) begin
               next_count = PRESET;
            end else if (tick_req) begin
               if (!at_end) begin
                  next_count = count - rtcrc_count_t'(1);
               end else if (TIMER1_AUTO_RELOAD) begin
                  next_count = PRESET;
               end else begin
                  next_count = '0;
               end
            end
         end
         default: begin
            next_count = '0;
         end
      endcase
   end

   // Expiry pulse: only a counting tick at the end point raises it
   assign next_expired = (state == RTCRC_RUN) && tick_req && at_end;

   // Run state register
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         state <= RTCRC_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Count register
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         count <= '0;
      end else begin
         count <= next_count;
      end
   end

   // Expiry pulse register, high for one cycle after the expiring tick
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         EXPIRED <= 1'b0;
      end else begin
         EXPIRED <= next_expired;
      end
   end

   // Outputs
   assign COUNT = count;
   assign RUNNING = (state == RTCRC_RUN);
   assign TIMER_TICK = tick;
endmodule

// ### sim/rtcrc_timer_sva.sv
// Checker for the timer tick and reload control.
// Bound to rtcrc_timer; sees its ports only.
`timescale 1ns/10ps
module rtcrc_sva (
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic TIMER1_CLOCK_SOURCE_SELECT,
   input wire logic TIMER1_AUTO_RELOAD,
   input wire rtcrc_pkg::rtcrc_count_t PRESET,
   input wire logic START,
   input wire logic STOP,
   input wire logic TIMER_TICK,
   input wire rtcrc_pkg::rtcrc_count_t COUNT,
   input wire logic RUNNING,
   input wire logic EXPIRED
);
   import rtcrc_pkg::*;
   default clocking @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   // Tick that really counts
   wire t = TIMER_TICK && RUNNING && !START && !STOP;
   wire s = TIMER1_CLOCK_SOURCE_SELECT;
   AST_SRC0: assert property ((!s)[*3] |->
      TIMER_TICK || $past(TIMER_TICK) || $past(TIMER_TICK, 2)) else $error("slow tick");
   AST_PRE: assert property (s && TIMER_TICK |=> (!TIMER_TICK)[*2]) else $error("fast tick");
   AST_LOAD: assert property (START && !STOP |=> COUNT == $past(PRESET) && RUNNING)
      else $error("no load");
   AST_DEC: assert property (t && COUNT > 1 |=> COUNT == $past(COUNT) - 1)
      else $error("no decrement");
   AST_EXP: assert property (t && COUNT <= 1 |=> EXPIRED) else $error("no expiry");
   AST_HALT: assert property (EXPIRED && !$past(TIMER1_AUTO_RELOAD) |-> COUNT == 0)
      else $error("no halt");
   AST_RLD: assert property (EXPIRED && $past(TIMER1_AUTO_RELOAD) |-> RUNNING)
      else $error("no reload");
   AST_HELD: assert property (!RUNNING && !START |=> $stable(COUNT)) else $error("moved");
endmodule
bind rtcrc_timer rtcrc_sva u_sva (.*);

// ### sim/tb_top.sv
// Bench for the timer tick and reload control.
// Drives all pins directly; checker is bound.
`timescale 1ns/10ps
module tb_top;
   import rtcrc_pkg::*;
   logic clk = 0, rst = 1, src = 0, rld = 0, start = 0, stop = 0, tick, running, expired;
   rtcrc_div_sel_t sel = 3'h0;
   rtcrc_count_t count;
   rtcrc_count_t preset = 20'h3;
   int errors = 0, samples_checked = 0;
   rtcrc_timer uut (.CLK(clk), .SYS_RST(rst), .TIMER1_CLOCK_SOURCE_SELECT(src),
      .TIMER1_DIVIDER_SELECT(sel), .TIMER1_AUTO_RELOAD(rld), .PRESET(preset), .START(start),
      .STOP(stop), .TIMER_TICK(tick), .COUNT(count), .RUNNING(running), .EXPIRED(expired));
   initial forever #12.5 clk = ~clk;
   task automatic chk(input logic [31:0] got, exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t %h %h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      if (errors == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Cycles to the next tick
   task automatic wait_tick(output int n);
      n = 0;
      do begin
         @(negedge clk);
         n++;
         if (n > 2000) begin
            errors++;
            summarize();
         end
      end while (!tick);
   endtask
   task automatic t_div(input logic s, input int k);
      int d;
      int w;
      repeat (3) @(posedge clk);
      #1;
      src = s;
      sel = 3'(k);
      w = s ? 2 << k : 1;
      wait_tick(d);
      wait_tick(d);
      chk(d * 13560 > (w - 1) * 40000 && d * 13560 < (w + 1) * 40000, 1);
   endtask
   task automatic t_run(input logic r, input rtcrc_count_t p);
      int m = 0;
      repeat (3) @(posedge clk);
      #1;
      sel = 3'h0;
      rld = r;
      preset = p;
      start = 1;
      @(posedge clk) #1;
      start = 0;
      chk(count, p);
      for (int c = 0; c < 99 && !expired; c++) begin
         @(negedge clk);
         m += tick & running;
      end
      chk({m[30:0], expired}, 32'({p, 1'b1}));
      chk({count, running}, r ? 32'({p, 1'b1}) : 32'h0);
      repeat (9) @(negedge clk);
      chk(count == 0, !r);
      @(posedge clk) #1;
      stop = 1;
      @(posedge clk) #1;
      stop = 0;
      chk(running, 0);
      start = 1;
      stop = 1;
      @(posedge clk) #1;
      start = 0;
      stop = 0;
      chk(running, 0);
   endtask
   initial begin
      repeat (3) @(posedge clk);
      #1 rst = 0;
      chk({count, running, expired}, 0);
      t_div(0, 0);
      for (int k = 0; k < 8; k++) t_div(1, k);
      t_run(0, 20'h3);
      t_run(1, 20'h5);
      summarize();
   end
endmodule
